//--- rtl/meter_seq_pkg.sv
package meter_seq_pkg;
  // ==========================================
  // timing
  localparam int CLK_KHZ = 10000;
  localparam int SUPPLY_DELAY_MS = 26;
  localparam int POWER_UP_MS = 40;
  localparam int RESET_LOW_US = 10;
  localparam int SUPPLY_DELAY_CYC = SUPPLY_DELAY_MS * CLK_KHZ;
  localparam int TRANSITION_CYC = (POWER_UP_MS - SUPPLY_DELAY_MS) * CLK_KHZ;
  localparam int RESET_LOW_CYC = RESET_LOW_US * CLK_KHZ / 1000;
  localparam int SPI_TOGGLES = 3;
  localparam int SS_HALF_CYC = 4;

  // ==========================================
  // device registers, reached over the link
  localparam logic [2:0] IDX_CFG = 3'h0;
  localparam logic [2:0] IDX_CFG2 = 3'h1;
  localparam logic [2:0] IDX_FIRST_STATUS_REGISTER = 3'h2;
  localparam logic [2:0] IDX_SECOND_STATUS_REGISTER = 3'h3;
  localparam logic [2:0] IDX_LP_THRESH = 3'h4;
  localparam logic [2:0] IDX_RUN = 3'h5;
  localparam int SOFT_RESET_BIT = 7;
  localparam int I2C_LOCK_BIT = 1;
  localparam int RESET_DONE_BIT = 15;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] CFG2_RST = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] LP_THRESH_RST = 16'h0000;
  localparam logic [15:0] RUN_RST = 16'h0000;
  localparam logic [15:0] RUN_START = 16'h0001;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [4:0] DEV_SYNC_INIT = 5'h07;

  // ==========================================
  // host controller registers, reached over apb
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam int CTRL_HW_RESET = 0;
  localparam int CTRL_SPI_SEL = 1;
  localparam int CTRL_START_DSP = 2;
  localparam int CTRL_SOFT_RESET = 3;
  localparam int CTRL_LOCK = 4;
  localparam int CTRL_USE_SPI = 5;
  localparam int CTRL_PM_A = 6;
  localparam int CTRL_PM_B = 7;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_S1_LSB = 16;

  typedef enum logic [1:0] {
    normal_power_mode, reduced_power_mode, low_power_mode, sleep_power_mode
  } power_mode_t;

  typedef enum logic [2:0] {
    inactive, supply_wait, transition, normal, hw_hold, low_power
  } dev_state_t;

  typedef enum logic [2:0] {
    h_idle, h_rst_low, h_ss_high, h_ss_low, h_rd_wait, h_clear0
  } host_state_t;
endpackage

//--- rtl/meter_link_if.sv
`timescale 1ns/1ps
interface meter_link_if;
  logic reset_pin_n;
  logic slave_select_pin_n;
  logic mode_select_pin_a;
  logic mode_select_pin_b;
  logic second_interrupt_pin_n;
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_rvalid;

  modport device (
    input reset_pin_n, slave_select_pin_n, mode_select_pin_a,
    input mode_select_pin_b, reg_wr, reg_rd, reg_addr, reg_wdata,
    output second_interrupt_pin_n, reg_rdata, reg_rvalid
  );
  modport host (
    output reset_pin_n, slave_select_pin_n, mode_select_pin_a,
    output mode_select_pin_b, reg_wr, reg_rd, reg_addr, reg_wdata,
    input second_interrupt_pin_n, reg_rdata, reg_rvalid
  );
endinterface // meter_link_if

//--- rtl/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sync_t;

  sync_t s;
  sync_t next_s;

  always_comb begin
    next_s.meta = din;
    next_s.sync = s.meta;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '{meta: INIT, sync: INIT};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign dout = s.sync;
endmodule // sync2

//--- rtl/meter_reset_seq.sv
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
module meter_reset_seq #(
  parameter int SUPPLY_DELAY_CYCLES = meter_seq_pkg::SUPPLY_DELAY_CYC,
  parameter int TRANSITION_CYCLES = meter_seq_pkg::TRANSITION_CYC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic supply_good,
  input wire logic [15:0] flag_events,
  meter_link_if.device link,
  output logic measuring_active,
  output logic dsp_running,
  output logic spi_active,
  output logic port_locked,
  output meter_seq_pkg::power_mode_t power_mode
);
  typedef struct packed {
    meter_seq_pkg::dev_state_t st;
    meter_seq_pkg::power_mode_t mode;
    logic [31:0] cnt;
    logic [1:0] toggles;
    logic ss_prev;
    logic spi;
    logic locked;
    logic [15:0] cfg;
    logic [15:0] cfg2;
    logic [15:0] first_status_register;
    logic [15:0] second_status_register;
    logic [15:0] lp_thresh;
    logic [15:0] run;
    logic irq_n;
    logic [15:0] rdata;
    logic rvalid;
    logic dsp_run;
    logic active;
  } state_t;

  localparam state_t ST_RST = '{
    st: meter_seq_pkg::inactive,
    mode: meter_seq_pkg::normal_power_mode,
    cnt: 32'h0000_0000,
    toggles: 2'h0,
    ss_prev: 1'b1,
    spi: 1'b0,
    locked: 1'b0,
    cfg: meter_seq_pkg::CFG_RST,
    cfg2: meter_seq_pkg::CFG2_RST,
    first_status_register: meter_seq_pkg::STATUS_RST,
    second_status_register: meter_seq_pkg::STATUS_RST,
    lp_thresh: meter_seq_pkg::LP_THRESH_RST,
    run: meter_seq_pkg::RUN_RST,
    irq_n: 1'b1,
    rdata: 16'h0000,
    rvalid: 1'b0,
    dsp_run: 1'b0,
    active: 1'b0
  };

  state_t s;
  state_t next_s;
  logic [4:0] pins;
  logic sup_ok;
  logic pm_b;
  logic pm_a;
  logic ss_n;
  logic rst_n;
  meter_seq_pkg::power_mode_t pin_mode;

  // =========================================
  // pin synchronisers
  sync2 #(
    .WIDTH(5),
    .INIT(meter_seq_pkg::DEV_SYNC_INIT)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .din({supply_good, link.mode_select_pin_b, link.mode_select_pin_a,
          link.slave_select_pin_n, link.reset_pin_n}),
    .dout(pins)
  );

  assign {sup_ok, pm_b, pm_a, ss_n, rst_n} = pins;

  always_comb begin
    unique case ({pm_b, pm_a})
      2'b01: pin_mode = meter_seq_pkg::normal_power_mode;
      2'b00: pin_mode = meter_seq_pkg::reduced_power_mode;
      2'b10: pin_mode = meter_seq_pkg::low_power_mode;
      2'b11: pin_mode = meter_seq_pkg::sleep_power_mode;
    endcase
  end

  // soft reset passes keep_port so cfg2, threshold and port survive
  function automatic state_t to_defaults(state_t x, logic keep_port);
    state_t y;
    y = x;
    y.cfg = meter_seq_pkg::CFG_RST;
    y.first_status_register = meter_seq_pkg::STATUS_RST;
    y.second_status_register = meter_seq_pkg::STATUS_RST;
    y.run = meter_seq_pkg::RUN_RST;
    y.toggles = 2'h0;
    if (!keep_port) begin
      y.cfg2 = meter_seq_pkg::CFG2_RST;
      y.lp_thresh = meter_seq_pkg::LP_THRESH_RST;
      y.spi = 1'b0;
      y.locked = 1'b0;
    end
    return y;
  endfunction

  // =========================================
  // sequencer and register file
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.ss_prev = ss_n;
    if (!sup_ok) begin
      next_s = ST_RST;
    end else begin
      unique case (s.st)
        meter_seq_pkg::inactive: begin
          next_s.st = meter_seq_pkg::supply_wait;
          next_s.cnt = 32'h0000_0000;
        end
        meter_seq_pkg::supply_wait: begin
          if (s.cnt == 32'(SUPPLY_DELAY_CYCLES - 1)) begin
            next_s = to_defaults(s, 1'b0);
            next_s.ss_prev = ss_n;
            next_s.mode = meter_seq_pkg::normal_power_mode;
            next_s.st = meter_seq_pkg::transition;
            next_s.cnt = 32'h0000_0000;
          end else begin
            next_s.cnt = s.cnt + 32'h0000_0001;
          end
        end
        meter_seq_pkg::transition: begin
          next_s.second_status_register[meter_seq_pkg::RESET_DONE_BIT] = 1'b0;
          if (s.cnt == 32'(TRANSITION_CYCLES - 1)) begin
            next_s.st = meter_seq_pkg::normal;
            next_s.cfg[meter_seq_pkg::SOFT_RESET_BIT] = 1'b0;
            next_s.second_status_register[meter_seq_pkg::RESET_DONE_BIT] = 1'b1;
          end else begin
            next_s.cnt = s.cnt + 32'h0000_0001;
          end
        end
        meter_seq_pkg::normal: begin
          if (pin_mode != meter_seq_pkg::normal_power_mode) begin
            next_s.st = meter_seq_pkg::low_power;
            next_s.mode = pin_mode;
          end else if (!rst_n) begin
            next_s.st = meter_seq_pkg::hw_hold;
            next_s.cnt = 32'h0000_0000;
          end else if (s.cfg[meter_seq_pkg::SOFT_RESET_BIT]) begin
            next_s = to_defaults(s, 1'b1);
            next_s.ss_prev = ss_n;
            next_s.cfg[meter_seq_pkg::SOFT_RESET_BIT] = 1'b1;
            next_s.st = meter_seq_pkg::transition;
            next_s.cnt = 32'h0000_0000;
          end else if (link.reg_wr) begin
            unique case (link.reg_addr)
              meter_seq_pkg::IDX_CFG: next_s.cfg = link.reg_wdata;
              meter_seq_pkg::IDX_CFG2: begin
                next_s.cfg2 = link.reg_wdata;
                if (s.spi) begin
                  next_s.locked = 1'b1;
                end else if (link.reg_wdata[meter_seq_pkg::I2C_LOCK_BIT]) begin
                  next_s.locked = 1'b1;
                end
              end
              meter_seq_pkg::IDX_FIRST_STATUS_REGISTER: begin
                next_s.first_status_register = s.first_status_register & ~link.reg_wdata;
              end
              meter_seq_pkg::IDX_SECOND_STATUS_REGISTER: begin
                next_s.second_status_register = s.second_status_register & ~link.reg_wdata;
              end
              meter_seq_pkg::IDX_LP_THRESH: next_s.lp_thresh = link.reg_wdata;
              meter_seq_pkg::IDX_RUN: next_s.run = link.reg_wdata;
              default: next_s.cfg = s.cfg;
            endcase
          end
          // events land after the clear so a same-cycle event is kept
          next_s.first_status_register = next_s.first_status_register | flag_events;
        end
        meter_seq_pkg::hw_hold: begin
          if (rst_n) begin
            if (s.cnt >= 32'(meter_seq_pkg::RESET_LOW_CYC - 1)) begin
              next_s = to_defaults(s, 1'b0);
              next_s.ss_prev = ss_n;
              next_s.st = meter_seq_pkg::transition;
              next_s.cnt = 32'h0000_0000;
            end else begin
              next_s.st = meter_seq_pkg::normal;
            end
          end else if (s.cnt != 32'hFFFF_FFFF) begin
            next_s.cnt = s.cnt + 32'h0000_0001;
          end
        end
        meter_seq_pkg::low_power: begin
          // reset pin and soft reset bit are ignored here
          next_s.mode = pin_mode;
          if (pin_mode == meter_seq_pkg::normal_power_mode) begin
            next_s.st = meter_seq_pkg::transition;
            next_s.cnt = 32'h0000_0000;
          end
        end
      endcase

      // select falls also count during the transition so a host can
      // re-select spi right after releasing reset
      // a fall on the edge that ends the transition must still count
      if ((s.st == meter_seq_pkg::normal || s.st == meter_seq_pkg::transition)
          && (next_s.st == s.st || next_s.st == meter_seq_pkg::normal)
          && !s.locked && !s.spi
          && s.ss_prev && !ss_n) begin
        if (s.toggles == 2'(meter_seq_pkg::SPI_TOGGLES - 1)) begin
          next_s.spi = 1'b1;
          next_s.toggles = 2'h0;
        end else begin
          next_s.toggles = s.toggles + 2'h1;
        end
      end

      if (link.reg_rd) begin
        next_s.rvalid = 1'b1;
        unique case (link.reg_addr)
          meter_seq_pkg::IDX_CFG: next_s.rdata = s.cfg;
          meter_seq_pkg::IDX_CFG2: next_s.rdata = s.cfg2;
          meter_seq_pkg::IDX_FIRST_STATUS_REGISTER: next_s.rdata = s.first_status_register;
          meter_seq_pkg::IDX_SECOND_STATUS_REGISTER: next_s.rdata = s.second_status_register;
          meter_seq_pkg::IDX_LP_THRESH: next_s.rdata = s.lp_thresh;
          meter_seq_pkg::IDX_RUN: next_s.rdata = s.run;
          default: next_s.rdata = 16'h0000;
        endcase
      end
    end
    // flag is unmaskable: the pin follows it alone
    next_s.irq_n = ~next_s.second_status_register[meter_seq_pkg::RESET_DONE_BIT];
    next_s.active = next_s.st == meter_seq_pkg::normal;
    next_s.dsp_run = next_s.active
                     && next_s.run == meter_seq_pkg::RUN_START;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign link.second_interrupt_pin_n = s.irq_n;
  assign link.reg_rdata = s.rdata;
  assign link.reg_rvalid = s.rvalid;
  assign measuring_active = s.active;
  assign dsp_running = s.dsp_run;
  assign spi_active = s.spi;
  assign port_locked = s.locked;
  assign power_mode = s.mode;
endmodule // meter_reset_seq

//--- rtl/host_reset_ctrl.sv
`timescale 1ns/1ps
module host_reset_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  meter_link_if.host link
);
  typedef struct packed {
    meter_seq_pkg::host_state_t st;
    logic [31:0] cnt;
    logic [1:0] toggles;
    logic pend_hw;
    logic pend_spi;
    logic pend_start;
    logic pend_soft;
    logic pend_lock;
    logic use_spi;
    logic pm_a;
    logic pm_b;
    logic done;
    logic [15:0] s1;
    logic rst_n;
    logic ss_n;
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  localparam state_t ST_RST = '{
    st: meter_seq_pkg::h_idle, cnt: 32'h0000_0000, toggles: 2'h0,
    pend_hw: 1'b0, pend_spi: 1'b0, pend_start: 1'b0, pend_soft: 1'b0,
    pend_lock: 1'b0, use_spi: 1'b0,
    pm_a: 1'b1, pm_b: 1'b0,
    done: 1'b0, s1: 16'h0000,
    rst_n: 1'b1,
    ss_n: 1'b1, wr: 1'b0, rd: 1'b0, addr: 3'h0, wdata: 16'h0000,
    prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0
  };

  state_t s;
  state_t next_s;
  logic irq_n;
  logic busy;

  sync2 #(
    .WIDTH(1),
    .INIT(1'b1)
  ) u_irq_sync (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .din(link.second_interrupt_pin_n),
    .dout(irq_n)
  );

  assign busy = s.st != meter_seq_pkg::h_idle || s.pend_hw || s.pend_spi
                || s.pend_start || s.pend_soft || s.pend_lock;

  // =========================================
  // link sequencer, then apb slave
  always_comb begin
    next_s = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    unique case (s.st)
      meter_seq_pkg::h_idle: begin
        next_s.cnt = 32'h0000_0000;
        next_s.toggles = 2'h0;
        if (s.pend_hw) begin
          next_s.pend_hw = 1'b0;
          next_s.rst_n = 1'b0;
          next_s.st = meter_seq_pkg::h_rst_low;
        end else if (s.pend_spi) begin
          next_s.pend_spi = 1'b0;
          next_s.st = meter_seq_pkg::h_ss_high;
        end else if (!irq_n) begin
          next_s.rd = 1'b1;
          next_s.addr = meter_seq_pkg::IDX_SECOND_STATUS_REGISTER;
          next_s.st = meter_seq_pkg::h_rd_wait;
        end else if (s.pend_soft) begin
          next_s.pend_soft = 1'b0;
          next_s.wr = 1'b1;
          next_s.addr = meter_seq_pkg::IDX_CFG;
          next_s.wdata = 16'h0000;
          next_s.wdata[meter_seq_pkg::SOFT_RESET_BIT] = 1'b1;
        end else if (s.pend_lock) begin
          next_s.pend_lock = 1'b0;
          next_s.wr = 1'b1;
          next_s.addr = meter_seq_pkg::IDX_CFG2;
          next_s.wdata = 16'h0000;
          next_s.wdata[meter_seq_pkg::I2C_LOCK_BIT] = 1'b1;
        end else if (s.pend_start) begin
          next_s.pend_start = 1'b0;
          next_s.wr = 1'b1;
          next_s.addr = meter_seq_pkg::IDX_RUN;
          next_s.wdata = meter_seq_pkg::RUN_START;
        end
      end
      meter_seq_pkg::h_rst_low: begin
        if (s.cnt == 32'(meter_seq_pkg::RESET_LOW_CYC - 1)) begin
          next_s.rst_n = 1'b1;
          next_s.cnt = 32'h0000_0000;
          next_s.st = s.use_spi ? meter_seq_pkg::h_ss_high
                                : meter_seq_pkg::h_idle;
        end else begin
          next_s.cnt = s.cnt + 32'h0000_0001;
        end
      end
      meter_seq_pkg::h_ss_high, meter_seq_pkg::h_ss_low: begin
        // half periods outlast the device's two-flop pin delay
        if (s.cnt == 32'(meter_seq_pkg::SS_HALF_CYC - 1)) begin
          next_s.cnt = 32'h0000_0000;
          if (s.st == meter_seq_pkg::h_ss_high) begin
            next_s.ss_n = 1'b0;
            next_s.st = meter_seq_pkg::h_ss_low;
          end else begin
            next_s.ss_n = 1'b1;
            next_s.toggles = s.toggles + 2'h1;
            next_s.st =
              (s.toggles == 2'(meter_seq_pkg::SPI_TOGGLES - 1))
              ? meter_seq_pkg::h_idle : meter_seq_pkg::h_ss_high;
          end
        end else begin
          next_s.cnt = s.cnt + 32'h0000_0001;
        end
      end
      meter_seq_pkg::h_rd_wait: begin
        if (link.reg_rvalid) begin
          next_s.s1 = link.reg_rdata;
          if (link.reg_rdata[meter_seq_pkg::RESET_DONE_BIT]) begin
            next_s.wr = 1'b1;
            next_s.addr = meter_seq_pkg::IDX_SECOND_STATUS_REGISTER;
            next_s.wdata = meter_seq_pkg::ALL_ONES;
            next_s.st = meter_seq_pkg::h_clear0;
          end else begin
            next_s.st = meter_seq_pkg::h_idle;
          end
        end
      end
      meter_seq_pkg::h_clear0: begin
        next_s.wr = 1'b1;
        next_s.addr = meter_seq_pkg::IDX_FIRST_STATUS_REGISTER;
        next_s.wdata = meter_seq_pkg::ALL_ONES;
        next_s.st = meter_seq_pkg::h_idle;
      end
    endcase

    next_s.pready = psel && !penable;
    next_s.pslverr = psel && !penable && paddr != meter_seq_pkg::ADDR_CTRL
                     && paddr != meter_seq_pkg::ADDR_STATUS;
    next_s.prdata = 32'h0000_0000;
    if (psel && !penable && paddr == meter_seq_pkg::ADDR_CTRL) begin
      next_s.prdata[meter_seq_pkg::CTRL_USE_SPI] = s.use_spi;
      next_s.prdata[meter_seq_pkg::CTRL_PM_A] = s.pm_a;
      next_s.prdata[meter_seq_pkg::CTRL_PM_B] = s.pm_b;
    end else if (psel && !penable && paddr == meter_seq_pkg::ADDR_STATUS) begin
      next_s.prdata[meter_seq_pkg::ST_BUSY] = busy;
      next_s.prdata[meter_seq_pkg::ST_DONE] = s.done;
      next_s.prdata[meter_seq_pkg::ST_IRQ] = irq_n;
      next_s.prdata[meter_seq_pkg::ST_S1_LSB +: 16] = s.s1;
    end
    if (psel && penable && s.pready && pwrite && !s.pslverr) begin
      if (paddr == meter_seq_pkg::ADDR_CTRL) begin
        next_s.pend_hw = s.pend_hw | pwdata[meter_seq_pkg::CTRL_HW_RESET];
        next_s.pend_spi = s.pend_spi | pwdata[meter_seq_pkg::CTRL_SPI_SEL];
        next_s.pend_start =
          s.pend_start | pwdata[meter_seq_pkg::CTRL_START_DSP];
        next_s.pend_soft =
          s.pend_soft | pwdata[meter_seq_pkg::CTRL_SOFT_RESET];
        next_s.pend_lock = s.pend_lock | pwdata[meter_seq_pkg::CTRL_LOCK];
        next_s.use_spi = pwdata[meter_seq_pkg::CTRL_USE_SPI];
        next_s.pm_a = pwdata[meter_seq_pkg::CTRL_PM_A];
        next_s.pm_b = pwdata[meter_seq_pkg::CTRL_PM_B];
      end else if (pwdata[meter_seq_pkg::ST_DONE]) begin
        next_s.done = 1'b0;
      end
    end
    // set after the clear so a completion in the same cycle is kept
    if (s.st == meter_seq_pkg::h_clear0) begin
      next_s.done = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= ST_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign link.reset_pin_n = s.rst_n;
  assign link.slave_select_pin_n = s.ss_n;
  assign link.mode_select_pin_a = s.pm_a;
  assign link.mode_select_pin_b = s.pm_b;
  assign link.reg_wr = s.wr;
  assign link.reg_rd = s.rd;
  assign link.reg_addr = s.addr;
  assign link.reg_wdata = s.wdata;
endmodule // host_reset_ctrl

//--- dv/meter_seq_checker.sv
`timescale 1ns/1ps
module meter_seq_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic reset_pin_n,
  input wire logic slave_select_pin_n,
  input wire logic mode_select_pin_a,
  input wire logic mode_select_pin_b,
  input wire logic second_interrupt_pin_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================
  // helpers
  int low_cnt;
  logic irq_seen;
  logic s1_sel;
  logic clr_s1;
  assign s1_sel = reg_addr == meter_seq_pkg::IDX_SECOND_STATUS_REGISTER;
  assign clr_s1 = reg_wr && s1_sel && reg_wdata[15];
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_cnt <= 0;
      irq_seen <= 1'b0;
    end else begin
      low_cnt <= reset_pin_n ? 0 : low_cnt + 1;
      irq_seen <= irq_seen | !second_interrupt_pin_n;
    end
  end
  // ==========================================
  // properties
  property p_rd; reg_rd |=> reg_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_rv; reg_rvalid |-> $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("stray rvalid");
  property p_one; reg_rvalid |=> !reg_rvalid; endproperty
  a_one: assert property (p_one) else $error("long rvalid");
  property p_irq;
    clr_s1 && !second_interrupt_pin_n |-> ##[1:3] second_interrupt_pin_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not released");
  // reads within two cycles of a clear are skipped; the pin clears on the same edge as the flag
  property p_done;
    reg_rd && s1_sel && !second_interrupt_pin_n && !$past(clr_s1)
      && !$past(clr_s1, 2) |=> reg_rdata[15];
  endproperty
  a_done: assert property (p_done) else $error("done flag low");
  property p_ss; $fell(slave_select_pin_n) |-> !slave_select_pin_n[*4];
  endproperty
  a_ss: assert property (p_ss) else $error("short select low");
  property p_rw; $rose(reset_pin_n) |-> low_cnt >= 100; endproperty
  a_rw: assert property (p_rw) else $error("short reset pulse");
  property p_pm; !irq_seen |-> mode_select_pin_a && !mode_select_pin_b;
  endproperty
  a_pm: assert property (p_pm) else $error("mode pins at start");
  property p_rh; !irq_seen |-> reset_pin_n; endproperty
  a_rh: assert property (p_rh) else $error("reset in power-up");
endmodule // meter_seq_checker

//--- dv/test_reset_and_port_select_seq.sv
`timescale 1ns/1ps
module test_reset_and_port_select_seq;
  logic mclk, reset, supply_good, psel, penable, pwrite, pready, pslverr;
  logic measuring_active, dsp_running, spi_active, port_locked, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  meter_seq_pkg::power_mode_t power_mode;
  int failures, compares;
  meter_link_if link ();
  // short counts keep the run brief
  meter_reset_seq #(.SUPPLY_DELAY_CYCLES(20), .TRANSITION_CYCLES(20))
    meter_reset_seq_i (.mclk(mclk), .reset(reset), .ce(1'b1),
    .supply_good(supply_good), .flag_events(16'h0000), .link(link),
    .measuring_active(measuring_active), .dsp_running(dsp_running),
    .spi_active(spi_active), .port_locked(port_locked),
    .power_mode(power_mode));
  host_reset_ctrl host_reset_ctrl_i (.mclk(mclk), .reset(reset),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  meter_seq_checker meter_seq_checker_i (.mclk(mclk), .reset(reset),
    .reset_pin_n(link.reset_pin_n),
    .slave_select_pin_n(link.slave_select_pin_n),
    .mode_select_pin_a(link.mode_select_pin_a),
    .mode_select_pin_b(link.mode_select_pin_b),
    .second_interrupt_pin_n(link.second_interrupt_pin_n),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .reg_rvalid(link.reg_rvalid));
  always #50 mclk = ~mclk;
  // ==========================================
  // shared tasks
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic ctrl(input logic [7:0] v);
    apb(1'b1, 12'h000, {24'h000000, v});
  endtask
  task automatic wait_done();
    do begin
      apb(1'b0, 12'h004, 32'h00000000);
    end while (rdat[1] !== 1'b1);
    check(rdat[31], "done flag not read");
    apb(1'b1, 12'h004, 32'h00000002);
  endtask
  task automatic test_done();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_power_up();
    supply_good <= 1'b1;
    repeat (10) @(posedge mclk);
    check(!measuring_active, "active too early");
    wait_done();
    check(measuring_active, "not active");
    check(!dsp_running && !spi_active, "dsp or spi");
  endtask
  task automatic t_spi_lock();
    ctrl(8'h44);
    repeat (3) @(posedge mclk);
    check(dsp_running, "dsp idle");
    ctrl(8'h42);
    repeat (60) @(posedge mclk);
    check(spi_active && !port_locked, "spi pick");
    ctrl(8'h50);
    repeat (10) @(posedge mclk);
    check(spi_active && port_locked, "spi lock");
  endtask
  task automatic t_soft();
    ctrl(8'h48);
    wait_done();
    check(spi_active && port_locked, "port lost");
    check(!dsp_running, "dsp runs");
  endtask
  task automatic t_low_power();
    ctrl(8'h80);
    repeat (10) @(posedge mclk);
    check(power_mode === meter_seq_pkg::low_power_mode, "mode");
    ctrl(8'h81);
    repeat (150) @(posedge mclk);
    check(spi_active, "reset acted");
    ctrl(8'h40);
    wait_done();
    check(spi_active && port_locked, "port lost");
  endtask
  task automatic t_hw_reset();
    ctrl(8'h61);
    wait_done();
    check(spi_active && !port_locked, "no spi re-select");
    ctrl(8'h41);
    wait_done();
    check(!spi_active && !port_locked, "no defaults");
  endtask
  task automatic t_i2c_lock();
    ctrl(8'h50);
    ctrl(8'h42);
    repeat (60) @(posedge mclk);
    check(port_locked && !spi_active, "i2c lock");
  endtask
  task automatic t_misc();
    apb(1'b0, 12'h008, 32'h00000000);
    check(rerr && rdat === 32'h00000000, "bad address");
    supply_good <= 1'b0;
    repeat (10) @(posedge mclk);
    check(!measuring_active && !dsp_running, "still active");
  endtask
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    {supply_good, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_power_up();
    t_spi_lock();
    t_soft();
    t_low_power();
    t_hw_reset();
    t_i2c_lock();
    t_misc();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    $display("mismatch at %0t: watchdog", $time);
    test_done();
  end
endmodule // test_reset_and_port_select_seq
